// ### rtl/msd_defines.svh
// constants for the memory segment decoder
`ifndef MSD_DEFINES_SVH
`define MSD_DEFINES_SVH
`define MSD_ADDR_W        32
`define MSD_SEG_W         4
`define MSD_SEG_LSB       28
`define MSD_SEG_PROGRAM_FLASH_C  4'h8
`define MSD_SEG_PMU_NC    4'ha
`define MSD_SEG_OVERLAY_RAM     4'hc
`define MSD_SEG_LOCAL     4'hd
`define MSD_OFF_W         28
`define MSD_BOOT_ROM_BASE 28'h0000000
`define MSD_BOOT_ROM_SIZE 28'h0008000
`define MSD_TEST_ROM_BASE 28'h0008000
`define MSD_TEST_ROM_SIZE 28'h0008000
`define MSD_LOCAL_DATA_RAM_BASE    28'h8000000
`define MSD_PF_BASE       28'h0000000
`define MSD_PF_SIZE       28'h0180000
`define MSD_DF_BASE       28'hf000000
`define MSD_DF_SIZE       28'h0008000
`define MSD_BR_BASE       28'hf800000
`define MSD_TR_BASE       28'hf808000
`endif

// ### rtl/msd_pkg.sv
// types for the memory segment decoder
package msd_pkg;
    // target memory of a decoded access
    typedef enum logic [3:0] {
        MSD_TGT_NONE,
        MSD_TGT_PROGRAM_FLASH,
        MSD_TGT_DATA_FLASH,
        MSD_TGT_BOOT_ROM,
        MSD_TGT_TEST_ROM,
        MSD_TGT_OVERLAY_RAM,
        MSD_TGT_SCRATCH_RAM,
        MSD_TGT_LOCAL_DATA_RAM
    } msd_target_t;
    // requesting master group
    typedef enum logic [1:0] {
        MSD_MST_PERIPHERAL,
        MSD_MST_CPU_PROGRAM,
        MSD_MST_CPU_DATA
    } msd_master_t;
    // answer state of a port
    typedef enum logic [1:0] {
        MSD_ST_IDLE,
        MSD_ST_RESP
    } msd_state_t;
endpackage

// ### rtl/msd_pmu_map.sv
// maps a pmu segment offset to one memory of the program memory unit
`timescale 1ns/1ps
`include "msd_defines.svh"
module msd_pmu_map (
    input  wire logic [`MSD_OFF_W-1:0] offset,
    output msd_pkg::msd_target_t       target
);
    // window test
    function automatic logic in_win(input logic [`MSD_OFF_W-1:0] a,
                                    input logic [`MSD_OFF_W-1:0] b,
                                    input logic [`MSD_OFF_W-1:0] s);
        in_win = (a >= b) && (a < b + s);
    endfunction

    // pick the memory whose window holds the offset
    always_comb begin
        if (in_win(offset, `MSD_PF_BASE, `MSD_PF_SIZE)) begin
            target = msd_pkg::MSD_TGT_PROGRAM_FLASH;
        end else if (in_win(offset, `MSD_DF_BASE, `MSD_DF_SIZE)) begin
            target = msd_pkg::MSD_TGT_DATA_FLASH;
        end else if (in_win(offset, `MSD_BR_BASE, `MSD_BOOT_ROM_SIZE)) begin
            target = msd_pkg::MSD_TGT_BOOT_ROM;
        end else if (in_win(offset, `MSD_TR_BASE, `MSD_TEST_ROM_SIZE)) begin
            target = msd_pkg::MSD_TGT_TEST_ROM;
        end else begin
            target = msd_pkg::MSD_TGT_NONE;    // hole inside the segment
        end
    end
endmodule // msd_pmu_map

// ### rtl/msd_local_map.sv
// maps a segment 13 offset for the cpu
`timescale 1ns/1ps
`include "msd_defines.svh"
module msd_local_map (
    input  wire logic [`MSD_OFF_W-1:0] offset,
    output msd_pkg::msd_target_t       target
);
    // rom windows low, local data ram high, scratch-pad in between
    always_comb begin
        if (offset >= `MSD_LOCAL_DATA_RAM_BASE) begin
            target = msd_pkg::MSD_TGT_LOCAL_DATA_RAM;
        end else if (offset < `MSD_TEST_ROM_BASE) begin
            target = msd_pkg::MSD_TGT_BOOT_ROM;
        end else if (offset < `MSD_TEST_ROM_BASE + `MSD_TEST_ROM_SIZE) begin
            target = msd_pkg::MSD_TGT_TEST_ROM;
        end else begin
            target = msd_pkg::MSD_TGT_SCRATCH_RAM;
        end
    end
endmodule // msd_local_map

// ### rtl/msd_memory_segment_decoder.sv
// address segment decoder for peripheral bus masters and cpu memory interfaces
`timescale 1ns/1ps
`include "msd_defines.svh"
module msd_memory_segment_decoder (
    input  wire logic                  sys_clk,
    input  wire logic                  arst_n,
    input  wire logic                  req_valid,      // one-cycle request strobe
    input  msd_pkg::msd_master_t       req_master,     // requesting master group
    input  wire logic [`MSD_ADDR_W-1:0] req_addr,      // byte address
    input  wire logic                  req_write,      // 1 write, 0 read
    output logic                       mem_valid_q,    // access issued to memory
    output msd_pkg::msd_target_t       mem_target_q,   // selected memory
    output logic [`MSD_OFF_W-1:0]      mem_offset_q,   // offset inside segment
    output logic                       mem_write_q,    // write qualifier
    output logic                       mem_cached_q,   // cacheable access
    output logic                       rsp_valid_q,    // answer strobe
    output logic                       rsp_error_q     // bus error answer
);
    logic [`MSD_SEG_W-1:0]   seg;                  // decoded segment
    logic [`MSD_OFF_W-1:0]   off;                  // offset in segment
    msd_pkg::msd_target_t    pmu_tgt;              // pmu memory by offset
    msd_pkg::msd_target_t    loc_tgt;              // segment 13 memory
    msd_pkg::msd_target_t    tgt;                  // final target
    logic                    cached;               // cacheable flag
    logic                    is_cpu;               // cpu side master
    logic                    err;                  // reserved or illegal

    logic                    mem_valid_d;
    msd_pkg::msd_target_t    mem_target_d;
    logic [`MSD_OFF_W-1:0]   mem_offset_d;
    logic                    mem_write_d;
    logic                    mem_cached_d;
    logic                    rsp_valid_d;
    logic                    rsp_error_d;

    // split the address
    assign seg = req_addr[`MSD_ADDR_W-1:`MSD_SEG_LSB];
    assign off = req_addr[`MSD_SEG_LSB-1:0];
    assign is_cpu = (req_master != msd_pkg::MSD_MST_PERIPHERAL);

    // memory window maps
    msd_pmu_map u_pmu_map (
        .offset (off),
        .target (pmu_tgt)
    );
    msd_local_map u_local_map (
        .offset (off),
        .target (loc_tgt)
    );

    // segment decode
    always_comb begin
        tgt    = msd_pkg::MSD_TGT_NONE;
        cached = 1'b0;
        case (seg)
            `MSD_SEG_PROGRAM_FLASH_C: begin
                tgt    = pmu_tgt;
                cached = is_cpu;
            end
            `MSD_SEG_PMU_NC: begin
                tgt    = pmu_tgt;
                cached = 1'b0;
            end
            `MSD_SEG_OVERLAY_RAM: begin
                if (is_cpu) begin
                    tgt    = msd_pkg::MSD_TGT_OVERLAY_RAM;
                    cached = 1'b1;
                end
                // peripheral masters find nothing here
            end
            `MSD_SEG_LOCAL: begin
                if (is_cpu) begin
                    tgt    = loc_tgt;
                    cached = 1'b0;
                end
                // peripheral masters find nothing here
            end
            default: begin
                tgt = msd_pkg::MSD_TGT_NONE;
            end
        endcase
    end

    // writes to the segment 13 roms are refused
    always_comb begin
        err = (tgt == msd_pkg::MSD_TGT_NONE);
        if (seg == `MSD_SEG_LOCAL && req_write &&
            (tgt == msd_pkg::MSD_TGT_BOOT_ROM || tgt == msd_pkg::MSD_TGT_TEST_ROM)) begin
            err = 1'b1;
        end
    end

    // next values of the outputs
    always_comb begin
        mem_valid_d  = req_valid && !err;
        mem_target_d = err ? msd_pkg::MSD_TGT_NONE : tgt;
        mem_offset_d = off;
        mem_write_d  = req_write && !err;
        mem_cached_d = cached && !err;
        rsp_valid_d  = req_valid && err;
        rsp_error_d  = req_valid && err;
        if (!req_valid) begin
            mem_target_d = msd_pkg::MSD_TGT_NONE;
            mem_offset_d = '0;
            mem_write_d  = 1'b0;
            mem_cached_d = 1'b0;
        end
    end

    // output registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_valid_q  <= 1'b0;
            mem_target_q <= msd_pkg::MSD_TGT_NONE;
            mem_offset_q <= '0;
            mem_write_q  <= 1'b0;
            mem_cached_q <= 1'b0;
            rsp_valid_q  <= 1'b0;
            rsp_error_q  <= 1'b0;
        end else begin
            mem_valid_q  <= mem_valid_d;
            mem_target_q <= mem_target_d;
            mem_offset_q <= mem_offset_d;
            mem_write_q  <= mem_write_d;
            mem_cached_q <= mem_cached_d;
            rsp_valid_q  <= rsp_valid_d;
            rsp_error_q  <= rsp_error_d;
        end
    end
endmodule // msd_memory_segment_decoder

// ### tb/msd_master_model.sv
// request side model of the bus masters and cpu interfaces
`timescale 1ns/1ps
module msd_master_model (
    input  wire logic           sys_clk,
    output msd_pkg::msd_master_t req_master,
    output logic                req_valid,
    output logic [31:0]         req_addr,
    output logic                req_write
);
    // one strobe per request, dropped on the edge that takes it
    task automatic issue(input msd_pkg::msd_master_t m, input logic [31:0] a, input logic w);
        @(posedge sys_clk);
        req_valid  <= 1'b1;
        req_master <= m;
        req_addr   <= a;
        req_write  <= w;
        @(posedge sys_clk);
        req_valid  <= 1'b0;
        req_addr   <= ~a; // released bus shows no stale address
    endtask
    // idle bus at time zero
    initial begin
        req_valid  = 1'b0;
        req_master = msd_pkg::MSD_MST_PERIPHERAL;
        req_addr   = 32'h0;
        req_write  = 1'b0;
    end
endmodule // msd_master_model

// ### tb/msd_checker.sv
// port assertions for the segment decoder
`timescale 1ns/1ps
module msd_checker (
    input wire logic           sys_clk,
    input wire logic           arst_n,
    input wire logic           req_valid,
    input msd_pkg::msd_master_t req_master,
    input wire logic [31:0]    req_addr,
    input wire logic           req_write,
    input wire logic           mem_valid_q,
    input msd_pkg::msd_target_t mem_target_q,
    input wire logic [27:0]    mem_offset_q,
    input wire logic           mem_write_q,
    input wire logic           mem_cached_q,
    input wire logic           rsp_valid_q,
    input wire logic           rsp_error_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    wire logic [3:0] seg = req_addr[31:28]; // segment field
    wire logic cpu = req_valid && req_master != msd_pkg::MSD_MST_PERIPHERAL; // cpu request
    wire logic per = req_valid && req_master == msd_pkg::MSD_MST_PERIPHERAL; // peripheral request
    property p_low; req_valid && !seg[3] |=> rsp_valid_q && rsp_error_q && !mem_valid_q; endproperty
    a_low: assert property (p_low) else $error("low segment not refused");
    property p_res; req_valid && (seg == 4'h9 || seg == 4'hb) |=> rsp_error_q && !mem_valid_q; endproperty
    a_res: assert property (p_res) else $error("segment 9 or 11 not refused");
    property p_per; per && seg[3:1] == 3'b110 |=> rsp_error_q && !mem_valid_q; endproperty
    a_per: assert property (p_per) else $error("peripheral upper segment not refused");
    property p_ovl; cpu && seg == 4'hc |=> mem_valid_q && mem_target_q == msd_pkg::MSD_TGT_OVERLAY_RAM; endproperty
    a_ovl: assert property (p_ovl) else $error("overlay not selected");
    property p_cach; mem_valid_q |-> mem_cached_q == ($past(cpu) && $past(seg) inside {4'h8, 4'hc}); endproperty
    a_cach: assert property (p_cach) else $error("cacheable flag wrong");
    property p_rom; cpu && seg == 4'hd && req_write && req_addr[27:16] == 12'h0 |=> rsp_error_q && !mem_valid_q; endproperty
    a_rom: assert property (p_rom) else $error("rom write not refused");
    property p_ld; cpu && seg == 4'hd && req_addr[27] |=> mem_target_q == msd_pkg::MSD_TGT_LOCAL_DATA_RAM; endproperty
    a_ld: assert property (p_ld) else $error("local ram not selected");
    property p_sp; cpu && seg == 4'hd && !req_addr[27] && req_addr[26:16] != 11'h0 |=> mem_valid_q && mem_target_q == msd_pkg::MSD_TGT_SCRATCH_RAM; endproperty
    a_sp: assert property (p_sp) else $error("scratch ram not selected");
    property p_off; mem_valid_q |-> mem_offset_q == $past(req_addr[27:0]) && !rsp_valid_q; endproperty
    a_off: assert property (p_off) else $error("offset wrong");
endmodule // msd_checker
bind msd_memory_segment_decoder msd_checker msd_checker_i (.sys_clk, .arst_n, .req_valid, .req_master, .req_addr,
    .req_write, .mem_valid_q, .mem_target_q, .mem_offset_q, .mem_write_q, .mem_cached_q, .rsp_valid_q, .rsp_error_q);

// ### tb/msd_memory_segment_decoder_tb.sv
// testbench for the memory segment decoder
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; $display("Error %s exp %0h got %0h", n, e, s); end end
module msd_memory_segment_decoder_tb;
    logic sys_clk, arst_n, req_valid, req_write, mem_valid_q, mem_write_q, mem_cached_q, rsp_valid_q, rsp_error_q;
    msd_pkg::msd_master_t req_master; // requesting group
    msd_pkg::msd_target_t mem_target_q; // decoded memory
    logic [31:0] req_addr; // request address
    logic [27:0] mem_offset_q; // decoded offset
    int bad_count, cmp_count; // tallies
    msd_master_model msd_master_model_i (.sys_clk, .req_master, .req_valid, .req_addr, .req_write);
    msd_memory_segment_decoder msd_memory_segment_decoder_i (.sys_clk, .arst_n, .req_valid, .req_master, .req_addr,
        .req_write, .mem_valid_q, .mem_target_q, .mem_offset_q, .mem_write_q, .mem_cached_q, .rsp_valid_q, .rsp_error_q);
    // one request, answer judged one cycle later
    task automatic xfer(int m, logic [31:0] a, logic w, msd_pkg::msd_target_t t, logic c);
        msd_master_model_i.issue(msd_pkg::msd_master_t'(m), a, w);
        #1;
        `CHK("error", t == msd_pkg::MSD_TGT_NONE, rsp_error_q)
        `CHK("answer", t == msd_pkg::MSD_TGT_NONE, rsp_valid_q)
        `CHK("valid", t != msd_pkg::MSD_TGT_NONE, mem_valid_q)
        `CHK("target", t, mem_target_q)
        `CHK("cached", c, mem_cached_q)
        if (t != msd_pkg::MSD_TGT_NONE) `CHK("offset", a[27:0], mem_offset_q)
        `CHK("write", w && t != msd_pkg::MSD_TGT_NONE, mem_write_q)
    endtask
    // reserved segments 0-7, 9 and 11 for every master
    task automatic t_reserved;
        for (int s = 0; s < 12; s++)
            if (s < 8 || s == 9 || s == 11)
                for (int m = 0; m < 3; m++) xfer(m, {s[3:0], 28'h0000100}, 1'b0, msd_pkg::MSD_TGT_NONE, 1'b0);
    endtask
    // pmu segments, each memory plus a window hole
    task automatic t_pmu;
        logic [27:0] off [4] = '{28'h017fffc, 28'hf000010, 28'hf800004, 28'hf808008};
        for (int s = 8; s < 11; s += 2)
            for (int m = 0; m < 3; m++) begin
                for (int k = 0; k < 4; k++)
                    xfer(m, {s[3:0], off[k]}, k[0], msd_pkg::msd_target_t'(k + 1), m != 0 && s == 8);
                xfer(m, {s[3:0], 28'h0180000}, 1'b0, msd_pkg::MSD_TGT_NONE, 1'b0);
            end
    endtask
    // segment 12 and 13 per master group
    task automatic t_upper;
        xfer(0, 32'hc0000040, 1'b0, msd_pkg::MSD_TGT_NONE, 1'b0);
        xfer(0, 32'hd8000000, 1'b1, msd_pkg::MSD_TGT_NONE, 1'b0);
        xfer(1, 32'hc0000040, 1'b1, msd_pkg::MSD_TGT_OVERLAY_RAM, 1'b1);
        xfer(2, 32'hc0001000, 1'b0, msd_pkg::MSD_TGT_OVERLAY_RAM, 1'b1);
        xfer(1, 32'hd0000004, 1'b0, msd_pkg::MSD_TGT_BOOT_ROM, 1'b0);
        xfer(2, 32'hd000fffc, 1'b0, msd_pkg::MSD_TGT_TEST_ROM, 1'b0);
        xfer(1, 32'hd0000004, 1'b1, msd_pkg::MSD_TGT_NONE, 1'b0);
        xfer(2, 32'hd000fffc, 1'b1, msd_pkg::MSD_TGT_NONE, 1'b0);
        xfer(1, 32'hd0010000, 1'b1, msd_pkg::MSD_TGT_SCRATCH_RAM, 1'b0);
        xfer(2, 32'hd7fffffc, 1'b0, msd_pkg::MSD_TGT_SCRATCH_RAM, 1'b0);
        xfer(2, 32'hd8000000, 1'b1, msd_pkg::MSD_TGT_LOCAL_DATA_RAM, 1'b0);
    endtask
    // verdict and end of run
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // 200 mhz clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // main sequence
    initial begin
        arst_n = 1'b0;
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_reserved();
        t_pmu();
        t_upper();
        test_done();
    end
    // hang guard, far beyond the roughly 150 cycles the run needs
    initial begin
        #100000;
        bad_count++;
        test_done();
    end
endmodule // msd_memory_segment_decoder_tb
